/* ssvi_pkg.sv */
package ssvi_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int SSVI_NSENSE      = 4;
   localparam int SSVI_VEC_W       = 12;
   localparam int SSVI_VBASE_W     = 10;
   localparam int SSVI_MAX_ELEM    = 31;
   localparam int SSVI_MAX_SRC     = 124;
   localparam logic [11:0] SSVI_VECTOR_FETCH_OP_OP = 12'o6047;
   // ****************************************
   // Device operations on the I/O bus
   // ****************************************
   typedef enum logic [2:0] {
      SSVI_OP_NONE, SSVI_OP_SKIP, SSVI_OP_WRITE_CTL_B_OP, SSVI_OP_WVEC,
      SSVI_OP_READ_CTL_A_OP, SSVI_OP_READ_STROBE_ONE, SSVI_OP_READ_STROBE_TWO, SSVI_OP_OTHER
   } ssvi_op_e;
   // Control register B field layout, per sense input i
   localparam int SSVI_CRB_SL_POS  = 0;
   localparam int SSVI_CRB_SP_POS  = 4;
   localparam int SSVI_CRB_IE_POS  = 8;
   // ****************************************
   // Controller register map (AHB-Lite)
   // ****************************************
   localparam logic [7:0] SSVI_OFF_CMD    = 8'h00;
   localparam logic [7:0] SSVI_OFF_DATA   = 8'h04;
   localparam logic [7:0] SSVI_OFF_STATUS = 8'h08;
   localparam logic [7:0] SSVI_OFF_RESULT = 8'h0C;
   localparam int SSVI_CMD_OP_POS  = 0;
   localparam int SSVI_CMD_SEL_POS = 4;
   localparam int SSVI_CMD_GNT_POS = 8;
   localparam logic [31:0] SSVI_RST_WORD = 32'h0000_0000;
endpackage : ssvi_pkg

/* ssvi_if.sv */
`timescale 1ns/1ps
interface ssvi_if;
   import ssvi_pkg::*;
   ssvi_op_e    op;
   logic [1:0]  op_sel;
   logic        addr_latch_strobe;
   logic        io_phase_second;
   logic [11:0] shared_data_bus_o;
   logic [11:0] shared_data_bus_i;
   logic        irq_grant;
   logic        priority_in;
   logic        priority_out;
   logic        irq_request_n_o;
   logic        irq_request_n_oe_n;
   logic        dir_ctl_first_o;
   logic        dir_ctl_first_oe_n;
   logic        skip_or_irq_line_o;
   logic        skip_or_irq_line_oe_n;
   modport dev (
      input  op, op_sel, addr_latch_strobe, io_phase_second,
             shared_data_bus_i, irq_grant, priority_in,
      output shared_data_bus_o, priority_out, irq_request_n_o,
             irq_request_n_oe_n, dir_ctl_first_o, dir_ctl_first_oe_n,
             skip_or_irq_line_o, skip_or_irq_line_oe_n
   );
   modport cpu (
      output op, op_sel, addr_latch_strobe, io_phase_second,
             shared_data_bus_i, irq_grant,
      input  shared_data_bus_o, irq_request_n_oe_n, dir_ctl_first_oe_n,
             skip_or_irq_line_oe_n
   );
endinterface : ssvi_if

/* ssvi_dev.sv */
`timescale 1ns/1ps
//
// Function
// - Chain up to 31 elements, 124 sources
// - Open-drain request low on enabled event
// - Processor raises grant, drops on transfer
// - Grant high freezes the priority chain
// - Selected element drives vector on transfer
// - Vector is base ten bits plus input
// - Software fetches vector with code 6047; here any transfer after grant fetches it
// - Chain input of top element tied high
// - Only enabled inputs may request
// - Level inputs never request or vector
// - First control line low when sourcing data
// - Per-input low, high, rising, falling sense
// - One latch per input, set when active
// - Skip reports latch then clears it
// - Level resets latch; edge passes once
// - Successful skip withdraws that request
// - Vector delivery leaves sense latch set
// - Without vectoring only skip clears request
// - Polarity rising in register B sets latch
// - Edge sets both; request updates on strobe
// - Request holds through second phase
// - Registers need not be initialised
module ssvi_dev (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   ssvi_if.dev                     bus,
   input  wire logic [3:0]         sense_in,
   output logic      [3:0]         sense_latch_q
);
   import ssvi_pkg::*;
   // ****************************************
   // Registers
   // ****************************************
   logic [11:0] ctl_reg_b_r;
   logic [9:0]  vbase_r;
   logic [3:0]  sense_latch_r, sense_nxt;
   logic [3:0]  irq_latch_r;
   logic [3:0]  sense_d_r;
   logic        sp_rise_any;
   logic        sel_frozen_r;
   logic [1:0]  src_frozen_r;
   logic [11:0] dout_r;
   logic        c1_r, skp_r, req_r, pout_r;
   wire  [3:0]  lvl   = ctl_reg_b_r[SSVI_CRB_SL_POS +: 4];
   wire  [3:0]  pol   = ctl_reg_b_r[SSVI_CRB_SP_POS +: 4];
   wire  [3:0]  ie    = ctl_reg_b_r[SSVI_CRB_IE_POS +: 4];
   wire  [3:0]  new_p = bus.shared_data_bus_i[SSVI_CRB_SP_POS +: 4];
   wire  [3:0]  new_l = bus.shared_data_bus_i[SSVI_CRB_SL_POS +: 4];
   wire         write_ctl_b_op  = (bus.op == SSVI_OP_WRITE_CTL_B_OP) && !bus.io_phase_second;
   // Only inputs left edge sensitive by this write see the internal edge
   wire  [3:0]  sp_up = write_ctl_b_op ? (new_p & ~pol & ~new_l) : 4'h0;
   wire  [3:0]  rise  = sense_in & ~sense_d_r;
   wire  [3:0]  fall  = ~sense_in & sense_d_r;
   // level: polarity picks high/low; edge: polarity picks rise/fall
   wire  [3:0]  lvl_hit  = lvl & ~(sense_in ^ pol);
   wire  [3:0]  edge_hit = ~lvl & ((pol & rise) | (~pol & fall) | sp_up);
   wire         skip_op  = (bus.op == SSVI_OP_SKIP) && !bus.io_phase_second;
   wire  [3:0]  skip_hit = skip_op ? (4'h1 << bus.op_sel) : 4'h0;
   wire         skip_ok  = |(skip_hit & sense_latch_r);
   wire  [3:0]  irq_src  = irq_latch_r & ie & ~lvl;
   wire         pending  = |irq_src;
   wire         any_xfer = (bus.op != SSVI_OP_NONE) && !bus.io_phase_second;
   wire         vec_now  = sel_frozen_r && any_xfer;
   wire         src_op   = (bus.op == SSVI_OP_READ_CTL_A_OP) ||
                           (bus.op == SSVI_OP_READ_STROBE_ONE) ||
                           (bus.op == SSVI_OP_READ_STROBE_TWO);
   function automatic logic [1:0] ssvi_first(input logic [3:0] v);
      ssvi_first = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
   endfunction : ssvi_first
   assign sp_rise_any = |sp_up;
   // set wins over skip clear; level re-sets at once
   assign sense_nxt = (sense_latch_r & ~(skip_hit & sense_latch_r))
                      | lvl_hit | edge_hit;
   // ****************************************
   // Sense, interrupt and register state
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sense_latch_r <= 4'h0;
         sense_d_r     <= 4'h0;
         ctl_reg_b_r   <= 12'h000; // cleared anyway for safety
         vbase_r       <= 10'h000;
      end else begin
         sense_latch_r <= sense_nxt; // vectoring does not clear
         sense_d_r     <= sense_in;
         if (write_ctl_b_op)
            ctl_reg_b_r <= bus.shared_data_bus_i;
         if ((bus.op == SSVI_OP_WVEC) && !bus.io_phase_second)
            vbase_r <= bus.shared_data_bus_i[11:2];
      end
   end
   // request copy follows latches only on the strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) irq_latch_r <= 4'h0;
      // Copy taken before this cycle's skip clear, so it drops next strobe
      else if (bus.addr_latch_strobe)
         irq_latch_r <= sense_latch_r | lvl_hit | edge_hit;
   end
   // freeze selection while grant is high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_frozen_r <= 1'b0;
         src_frozen_r <= 2'd0;
      end else if (!bus.irq_grant) begin
         sel_frozen_r <= 1'b0;
         src_frozen_r <= ssvi_first(irq_src);
      end else if (!sel_frozen_r && !pout_r) begin
         sel_frozen_r <= pending && bus.priority_in;
      end else if (vec_now) begin
         sel_frozen_r <= 1'b0;
      end
   end
   // ****************************************
   // Pin drivers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout_r <= 12'h000;
         c1_r   <= 1'b0;
         skp_r  <= 1'b0;
         req_r  <= 1'b0;
         pout_r <= 1'b0;
      end else begin
         dout_r <= vec_now ? {vbase_r, src_frozen_r} : 12'h000;
         c1_r   <= vec_now || (src_op && !bus.io_phase_second);
         skp_r  <= skip_ok;
         req_r  <= pending;
         // Hold chain output steady while grant freezes it
         if (!bus.irq_grant)
            pout_r <= bus.priority_in && !pending;
      end
   end
   assign bus.shared_data_bus_o      = dout_r;
   assign bus.irq_request_n_o        = 1'b0;
   assign bus.irq_request_n_oe_n     = ~req_r;
   assign bus.dir_ctl_first_o        = 1'b0;
   assign bus.dir_ctl_first_oe_n     = ~c1_r;
   assign bus.skip_or_irq_line_o     = 1'b0;
   assign bus.skip_or_irq_line_oe_n  = ~skp_r;
   assign bus.priority_out           = pout_r;
   assign sense_latch_q              = sense_latch_r;
   wire unused_ok = sp_rise_any;
endmodule : ssvi_dev

/* ssvi_cpu.sv */
`timescale 1ns/1ps
module ssvi_cpu (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   ssvi_if.cpu                     bus,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp
);
   import ssvi_pkg::*;
   typedef enum logic [1:0] {SSVI_IDLE, SSVI_PA, SSVI_PB} ssvi_st_e;
   // ****************************************
   // Bus slave
   // ****************************************
   ssvi_st_e    st_r;
   logic        wr_r;
   logic [7:0]  wa_r;
   logic [31:0] cmd_r, data_r, res_r, rd_r;
   logic        busy_r, grant_r, strobe_r, phb_r;
   ssvi_op_e    op_r;
   logic [11:0] dout_r;
   wire  acc   = hsel && hready && htrans[1];
   wire  go    = wr_r && (wa_r == SSVI_OFF_CMD) && !busy_r;
   wire  [31:0] status_w = {28'h0, ~bus.skip_or_irq_line_oe_n,
                            ~bus.dir_ctl_first_oe_n,
                            ~bus.irq_request_n_oe_n, busy_r};
   wire  [31:0] rmux = (haddr[7:0] == SSVI_OFF_CMD)    ? cmd_r :
                       (haddr[7:0] == SSVI_OFF_DATA)   ? data_r :
                       (haddr[7:0] == SSVI_OFF_STATUS) ? status_w :
                       (haddr[7:0] == SSVI_OFF_RESULT) ? res_r : 32'h0;
   wire  [31:0] cap = {19'h0, ~bus.skip_or_irq_line_oe_n,
                       bus.shared_data_bus_o};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         wa_r <= 8'h00;
         rd_r <= SSVI_RST_WORD;
         cmd_r <= SSVI_RST_WORD;
         data_r <= SSVI_RST_WORD;
      end else begin
         wr_r <= acc && hwrite;
         wa_r <= haddr[7:0];
         if (acc && !hwrite)
            rd_r <= rmux;
         if (go)
            cmd_r <= hwdata;
         if (wr_r && (wa_r == SSVI_OFF_DATA))
            data_r <= hwdata;
      end
   end
   // ****************************************
   // Two-phase I/O sequencer
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= SSVI_IDLE;
         busy_r <= 1'b0;
         op_r <= SSVI_OP_NONE;
         strobe_r <= 1'b0;
         phb_r <= 1'b0;
         grant_r <= 1'b0;
         dout_r <= 12'h000;
         res_r <= SSVI_RST_WORD;
      end else begin
         case (st_r)
            SSVI_IDLE: begin
               phb_r <= 1'b0;
               op_r <= SSVI_OP_NONE;
               if (go && hwdata[SSVI_CMD_GNT_POS]) begin
                  // Grant alone; the next transfer is the first after it
                  grant_r <= 1'b1;
               end else if (go) begin
                  busy_r <= 1'b1;
                  op_r <= ssvi_op_e'(hwdata[SSVI_CMD_OP_POS +: 3]);
                  dout_r <= data_r[11:0];
                  strobe_r <= 1'b1;
                  st_r <= SSVI_PA;
               end
            end
            SSVI_PA: begin
               strobe_r <= 1'b0;
               phb_r <= 1'b1;
               st_r <= SSVI_PB;
            end
            SSVI_PB: begin
               // Device answers one cycle after phase A
               res_r <= cap;
               op_r <= SSVI_OP_NONE;
               phb_r <= 1'b0;
               // Any transfer drops grant
               grant_r <= 1'b0;
               busy_r <= 1'b0;
               st_r <= SSVI_IDLE;
            end
            default: st_r <= SSVI_IDLE;
         endcase
      end
   end
   assign bus.op = op_r;
   assign bus.op_sel = cmd_r[SSVI_CMD_SEL_POS +: 2];
   assign bus.addr_latch_strobe = strobe_r;
   assign bus.io_phase_second = phb_r;
   assign bus.shared_data_bus_i = go ? hwdata[11:0] : dout_r;
   assign bus.irq_grant = grant_r;
   assign hrdata = rd_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule : ssvi_cpu

/* ssvi_checker.sv */
`timescale 1ns/1ps
module ssvi_checker (
   input wire logic           hclk,
   input wire logic           hresetn,
   input ssvi_pkg::ssvi_op_e  op,
   input wire logic           addr_latch_strobe,
   input wire logic           io_phase_second,
   input wire logic           irq_grant,
   input wire logic           priority_in,
   input wire logic           priority_out,
   input wire logic           irq_request_n_o,
   input wire logic           irq_request_n_oe_n,
   input wire logic           dir_ctl_first_o,
   input wire logic           dir_ctl_first_oe_n
);
   import ssvi_pkg::*;
   // ****************************************
   // Sequences
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_src;
      addr_latch_strobe && (op inside {SSVI_OP_READ_CTL_A_OP, SSVI_OP_READ_STROBE_ONE,
                                       SSVI_OP_READ_STROBE_TWO});
   endsequence
   sequence s_vec;
      addr_latch_strobe && irq_grant && priority_in && !irq_request_n_oe_n;
   endsequence
   sequence s_c1;
      ##[1:3] !dir_ctl_first_oe_n;
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   a_req_od_low: assert property (!irq_request_n_oe_n |-> !irq_request_n_o)
      else $error("request pin not driven low");
   a_req_on_strobe: assert property ($changed(irq_request_n_oe_n) |->
      $past(addr_latch_strobe) || $past(addr_latch_strobe, 2))
      else $error("request changed away from a strobe");
   a_c1_on_read: assert property (s_src |-> s_c1)
      else $error("first control line idle on read");
   a_c1_od_low: assert property (!dir_ctl_first_oe_n |-> !dir_ctl_first_o)
      else $error("first control pin not driven low");
   a_vec_on_grant: assert property (s_vec |-> s_c1)
      else $error("no vector after grant");
   a_no_vec_blocked: assert property (addr_latch_strobe && irq_grant &&
      !priority_in && op == SSVI_OP_OTHER |=> dir_ctl_first_oe_n [*3])
      else $error("vector sent with chain blocked");
   a_chain_block: assert property (!priority_in &&
      $past(priority_in) == 1'b0 |-> !priority_out)
      else $error("chain passed with input low");
   a_grant_drops: assert property (irq_grant && addr_latch_strobe |->
      ##[1:4] !irq_grant)
      else $error("grant kept after transfer");
   a_strobe_pulse: assert property (addr_latch_strobe |=>
      !addr_latch_strobe && io_phase_second)
      else $error("strobe not followed by second phase");
endmodule : ssvi_checker

/* ssvi_tb_top.sv */
`timescale 1ns/1ps
module sense_skip_vectored_irq_tb_top;
   import ssvi_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, r, res;
   logic [3:0]  sense_in, latch_q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          bad_count, checked, cycles;
   ssvi_if bif ();
   ssvi_dev u_ssvi_dev (.hclk(hclk), .hresetn(hresetn), .bus(bif.dev),
      .sense_in(sense_in), .sense_latch_q(latch_q));
   ssvi_cpu u_ssvi_cpu (.hclk(hclk), .hresetn(hresetn), .bus(bif.cpu),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp));
   ssvi_checker u_ssvi_checker (.hclk(hclk), .hresetn(hresetn),
      .op(bif.op), .addr_latch_strobe(bif.addr_latch_strobe),
      .io_phase_second(bif.io_phase_second), .irq_grant(bif.irq_grant),
      .priority_in(bif.priority_in), .priority_out(bif.priority_out),
      .irq_request_n_o(bif.irq_request_n_o),
      .irq_request_n_oe_n(bif.irq_request_n_oe_n),
      .dir_ctl_first_o(bif.dir_ctl_first_o),
      .dir_ctl_first_oe_n(bif.dir_ctl_first_oe_n));
   // ****************************************
   // Tasks
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task close_out;
      $display("mismatches %0d compares %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : ahb
   // Polls busy; a stuck device ends in the timeout
   task io(input ssvi_op_e o, input logic [1:0] s, input logic g);
      ahb(1'b1, SSVI_OFF_CMD, {23'h00_0000, g, 2'h0, s, 1'b0, o});
      do ahb(1'b0, SSVI_OFF_STATUS, 32'h0000_0000); while (r[0] !== 1'b0);
      ahb(1'b0, SSVI_OFF_RESULT, 32'h0000_0000);
      res = r;
   endtask : io
   task wr(input ssvi_op_e o, input logic [11:0] v);
      ahb(1'b1, SSVI_OFF_DATA, {20'h0_0000, v});
      io(o, 2'h0, 1'b0);
   endtask : wr
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   // ****************************************
   // Sequence of tests
   // ****************************************
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      sense_in = 4'h9;
      bif.priority_in = 1'b1;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      wr(SSVI_OP_WVEC, 12'h5A0);
      // In0 low, in1 high, in2 rising, in3 falling; enables on 0 and 2
      wr(SSVI_OP_WRITE_CTL_B_OP, 12'h563);
      chk(latch_q, 4'h4);
      for (int i = 0; i < 4; i++) begin
         io(SSVI_OP_SKIP, i[1:0], 1'b0);
         chk(res[12], i == 2);
      end
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(bif.irq_request_n_oe_n, 1'h1);
      sense_in <= 4'h6;
      repeat (3) @(posedge hclk);
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(latch_q, 4'hF);
      chk(bif.irq_request_n_oe_n, 1'h0);
      io(SSVI_OP_OTHER, 2'h0, 1'b1);
      io(SSVI_OP_OTHER, 2'h0, 1'b0); // vector fetch transfer
      chk(res[11:0], 12'h5A2);
      chk(latch_q[2], 1'h1);
      for (int i = 0; i < 4; i++) begin
         io(SSVI_OP_SKIP, i[1:0], 1'b0);
         chk(res[12], 1'h1);
         if (i == 2) chk(bif.irq_request_n_oe_n, 1'h0);
         io(SSVI_OP_SKIP, i[1:0], 1'b0);
         chk(res[12], i < 2);
      end
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(bif.irq_request_n_oe_n, 1'h1);
      for (int k = 4; k < 7; k++) io(ssvi_op_e'(k), 2'h0, 1'b0);
      sense_in <= 4'h9;
      bif.priority_in <= 1'b0;
      @(posedge hclk);
      sense_in <= 4'hD;
      repeat (3) @(posedge hclk);
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(bif.priority_out, 1'h0);
      io(SSVI_OP_OTHER, 2'h0, 1'b1);
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(res[11:0], 12'h000);
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(bif.irq_request_n_oe_n, 1'h0);
      io(SSVI_OP_SKIP, 2'h2, 1'b0);
      io(SSVI_OP_OTHER, 2'h0, 1'b0);
      chk(bif.irq_request_n_oe_n, 1'h1);
      close_out();
   end
endmodule : sense_skip_vectored_irq_tb_top
